//--- rtl/secs_pkg.sv
// Purpose: shared constants and types of the serial eeprom command slave
// Assumes: 10-bit byte address, 16-byte pages, 50 MHz reference clock
// Notes:   opcodes are the low three bits; bits 4:3 carry page or don't care
package secs_pkg;

  // --------------------------------------------------------------------
  // array geometry
  // --------------------------------------------------------------------
  localparam int          ADDR_W         = 10;
  localparam int          MEM_DEPTH      = 1024;
  localparam int          PAGE_BYTES     = 16;
  localparam logic [9:0]  ADDR_WRAP      = 10'h1ff;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  localparam logic [9:0]  PROT_QTR_BASE  = 10'h300;
  localparam logic [9:0]  PROT_HALF_BASE = 10'h200;
  localparam logic [1:0]  PROT_NONE      = 2'h0;
  localparam logic [1:0]  PROT_QTR       = 2'h1;
  localparam logic [1:0]  PROT_HALF      = 2'h2;
  localparam logic [1:0]  PROT_INIT      = 2'h0;

  // --------------------------------------------------------------------
  // instruction byte fields
  // --------------------------------------------------------------------
  localparam logic [2:0]  OP_HIGH_ZERO       = 3'h0;
  localparam logic [2:0]  OP_LATCH_SET       = 3'h6;
  localparam logic [2:0]  OP_LATCH_CLEAR     = 3'h4;
  localparam logic [2:0]  OP_STATUS_FETCH    = 3'h5;
  localparam logic [2:0]  OP_STATUS_PROGRAM  = 3'h1;
  localparam logic [2:0]  OP_ARRAY_READ      = 3'h3;
  localparam logic [2:0]  OP_ARRAY_WRITE     = 3'h2;
  localparam logic [3:0]  STATUS_ONES        = 4'hf;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int          REF_PERIOD_NS   = 20;
  localparam int          T_WRITE_MS      = 10;
  localparam int          WRITE_CYCLES    = T_WRITE_MS * 1000000 / REF_PERIOD_NS;
  localparam int          CYC_CNT_W       = 20;
  localparam int          ARM_CLEAR_LEAD  = 1;

  typedef enum logic [2:0] {
    PH_CMD, PH_ADDR, PH_RDATA, PH_SFETCH, PH_SPROG, PH_SDONE, PH_WDATA, PH_IDLE
  } secs_phase_t;

  typedef enum logic [2:0] {
    K_NONE, K_SET, K_CLR, K_SFETCH, K_SPROG, K_READ, K_WRITE
  } secs_kind_t;

endpackage : secs_pkg

//--- rtl/secs_sync.sv
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is an independent slow level
// Notes:   first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module secs_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         i_clk,  // destination clock
  input  wire logic [W-1:0] i_d,    // asynchronous level
  output logic      [W-1:0] o_q     // synchronised level
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } secs_sync_t;

  secs_sync_t s_q = {INIT, INIT};
  secs_sync_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.meta = i_d;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge i_clk) begin
    s_q <= s_d;
  end

  assign o_q = s_q.stab;

endmodule : secs_sync
`default_nettype wire

//--- rtl/secs_top.sv
// Purpose: device-side command front end of a 1K x 8 serial eeprom
// Assumes: serial clock idles low between frames; hold is sampled with data
// Notes:   link logic runs on I_SCK, program engine on I_REF_CLK
//
// Operation
// R1: read is instruction then low address byte
// R2: instruction bits 4:3 select array page
// R3: read data shifted out after falling edges
// R4: read address increments after every byte
// R5: read address wraps from top to zero; the code wraps at ADDR_WRAP (10'h1ff) to zero, and at 10'h3ff only for reads that start above 10'h1ff
// R6: deselect stops output and ends frame
// R7: array read during programming deselects device
// R8: decode latch set, clear, status fetch
// R9: decode status program, array read, write
// R10: protect bits block writes to upper ranges
// R11: host arms latch in separate frame first
// R12: write cancelled unless deselect after byte
// R13: program cycle starts at deselect, shows busy
// R14: latch cleared near end of program cycle
// R15: page write carries up to sixteen bytes
// R16: page address low nibble wraps in page
// R17: program only if deselect byte aligned, clock low
// R18: power-up: idle, latch clear, protect kept
// R19: deselect with clock high is ignored
// R20: array access while busy cancelled, cycle continues
// R21: after short instructions wait for deselect
// R22: lock pin clears latch; array erased initially
// R23: status byte ones, protect, armed, busy
// R24: latch cleared by reset, lock, clear, program
// R25: status program needs exactly eight data bits
// R26: msb first; unknown instruction deselects device
// R27: program time counted in reference clocks
`timescale 1ns/10ps
`default_nettype none
module secs_top
  import secs_pkg::*;
#(
  parameter int P_WRITE_CYCLES = secs_pkg::WRITE_CYCLES  // program cycle length
) (
  input  wire logic       I_REF_CLK,      // 50 MHz system clock
  input  wire logic       I_SRST,         // synchronous reset, high
  input  wire logic       I_SCK,          // serial clock from master
  input  wire logic       I_CS_N,         // chip enable, low selects
  input  wire logic       I_SDI,          // serial data in
  input  wire logic       I_HOLD_N,       // pause, low holds the link
  input  wire logic       I_LOCK_N,       // program lock, low disarms
  output logic            O_SDO,          // serial data out
  output logic            O_SDO_OE,       // serial data out enable
  output logic            O_CYCLE_ACTIVE, // program cycle running
  output logic            O_PROGRAM_ARMED,// write enable latch
  output logic [1:0]      O_PROTECT_SEL   // protect bits hi, lo
);

  // --------------------------------------------------------------------
  // types and storage
  // --------------------------------------------------------------------
  typedef struct packed {
    secs_phase_t            phase;
    logic [2:0]             bitcnt;
    logic [6:0]             sh;
    secs_kind_t             kind;
    logic [ADDR_W-1:0]      addr;
    logic [7:0]             tx;
    logic [PAGE_BYTES-1:0][7:0] wbuf;
    logic [PAGE_BYTES-1:0]  wmask;
    logic                   aligned;
    logic [1:0]             sdata;
  } secs_link_t;

  typedef struct packed {
    logic                   cs_prev;
    logic                   armed;
    logic [1:0]             prot;
    logic [1:0]             new_prot;
    logic                   pend_stat;
    logic                   busy;
    logic [CYC_CNT_W-1:0]   cnt;
    logic                   oe;
  } secs_ref_t;

  localparam secs_ref_t REF_INIT = '{
    cs_prev:   1'b1,
    armed:     1'b0,
    prot:      PROT_INIT,
    new_prot:  PROT_INIT,
    pend_stat: 1'b0,
    busy:      1'b0,
    cnt:       '0,
    oe:        1'b0
  };

  // nonvolatile array, delivered erased (R22)
  // one writer only: the program engine; the start value stands in the declaration
  logic [7:0] mem [MEM_DEPTH] = '{default: ERASED_BYTE};

  secs_link_t ln_q = '0;
  secs_link_t ln_d;
  secs_link_t cur;
  secs_ref_t  rf_q = REF_INIT;
  secs_ref_t  rf_d;
  logic       started_q = 1'b0;
  logic       tx_oe_q   = 1'b0;
  logic       sdo_q     = 1'b0;
  logic [3:0] stat_s;
  logic [3:0] pin_s;
  logic       oe_s;
  logic       wr_go;
  logic [7:0] byte_in;
  logic       last;
  logic [ADDR_W-1:0] next_addr;
  logic       cs_s;
  logic       sck_s;
  logic       hold_s;
  logic       lock_s;
  logic       rise;

  // --------------------------------------------------------------------
  // crossings
  // --------------------------------------------------------------------
  // status bits into the serial domain; the instruction byte gives
  // seven edges to settle before any status bit is looked at on the eighth
  secs_sync #(.W(4), .INIT(4'h0)) u_stat_sync (
    .i_clk (I_SCK),
    .i_d   ({rf_q.prot, rf_q.armed, rf_q.busy}),
    .o_q   (stat_s)
  );

  // idle levels: deselected, clock low, not held, not locked
  secs_sync #(.W(4), .INIT(4'hb)) u_pin_sync (
    .i_clk (I_REF_CLK),
    .i_d   ({I_CS_N, I_SCK, I_HOLD_N, I_LOCK_N}),
    .o_q   (pin_s)
  );

  secs_sync #(.W(1), .INIT(1'b0)) u_oe_sync (
    .i_clk (I_REF_CLK),
    .i_d   (tx_oe_q),
    .o_q   (oe_s)
  );

  assign cs_s   = pin_s[3];
  assign sck_s  = pin_s[2];
  assign hold_s = pin_s[1];
  assign lock_s = pin_s[0];

  // --------------------------------------------------------------------
  // link side: frame start marker
  // --------------------------------------------------------------------
  // the clock stops outside frames, so deselect itself marks the next
  // edge as the first bit of a new instruction
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // link side: shifter and decoder
  // --------------------------------------------------------------------
  always_comb begin
    cur = ln_q;
    if (!started_q) begin
      cur.phase   = PH_CMD;
      cur.bitcnt  = 3'h0;
      cur.kind    = K_NONE;
      cur.wmask   = '0;
      cur.aligned = 1'b0;
    end
    ln_d      = cur;
    byte_in   = {cur.sh, I_SDI};                                        // R26
    last      = (cur.bitcnt == 3'h7);
    next_addr = (cur.addr == ADDR_WRAP) ? '0 : cur.addr + 10'h001;      // R5
    if (I_HOLD_N) begin
      ln_d.sh     = byte_in[6:0];
      ln_d.bitcnt = cur.bitcnt + 3'h1;
      case (cur.phase)
        PH_CMD: begin
          if (last) begin
            ln_d.phase = PH_IDLE;                                       // R26
            ln_d.kind  = K_NONE;
            if (byte_in[7:5] == OP_HIGH_ZERO) begin
              case (byte_in[2:0])
                OP_LATCH_SET: begin
                  ln_d.kind = K_SET;                                    // R8
                end
                OP_LATCH_CLEAR: begin
                  ln_d.kind = K_CLR;                                    // R8
                end
                OP_STATUS_FETCH: begin
                  ln_d.kind  = K_SFETCH;                                // R8
                  ln_d.phase = PH_SFETCH;
                  ln_d.tx    = {STATUS_ONES, stat_s};                   // R23
                end
                OP_STATUS_PROGRAM: begin
                  if (!stat_s[0]) begin
                    ln_d.kind  = K_SPROG;                               // R9
                    ln_d.phase = PH_SPROG;
                  end
                end
                OP_ARRAY_READ: begin
                  if (!stat_s[0]) begin                                 // R7
                    ln_d.kind      = K_READ;                            // R9
                    ln_d.phase     = PH_ADDR;
                    ln_d.addr[9:8] = byte_in[4:3];                      // R2
                  end
                end
                OP_ARRAY_WRITE: begin
                  if (!stat_s[0]) begin                                 // R20
                    ln_d.kind      = K_WRITE;                           // R9
                    ln_d.phase     = PH_ADDR;
                    ln_d.addr[9:8] = byte_in[4:3];                      // R2
                  end
                end
                default: begin
                  ln_d.kind = K_NONE;
                end
              endcase
            end
          end
        end
        PH_ADDR: begin
          if (last) begin
            ln_d.addr[7:0] = byte_in;                                   // R1
            if (cur.kind == K_READ) begin
              ln_d.phase = PH_RDATA;
              ln_d.tx    = mem[{cur.addr[9:8], byte_in}];               // R3
            end else begin
              ln_d.phase = PH_WDATA;
            end
          end
        end
        PH_RDATA: begin
          if (last) begin
            ln_d.addr = next_addr;                                      // R4
            ln_d.tx   = mem[next_addr];
          end
        end
        PH_SFETCH: begin
          if (last) begin
            ln_d.phase = PH_IDLE;                                       // R21
          end
        end
        PH_SPROG: begin
          if (last) begin
            ln_d.sdata   = byte_in[3:2];
            ln_d.phase   = PH_SDONE;
            ln_d.aligned = 1'b1;
          end
        end
        PH_SDONE: begin
          // a ninth data clock spoils the status write
          ln_d.phase   = PH_IDLE;                                       // R25
          ln_d.aligned = 1'b0;
        end
        PH_WDATA: begin
          ln_d.aligned = 1'b0;                                          // R12
          if (last) begin
            ln_d.wbuf[cur.addr[3:0]]  = byte_in;                        // R15
            ln_d.wmask[cur.addr[3:0]] = 1'b1;
            ln_d.addr[3:0]            = cur.addr[3:0] + 4'h1;           // R16
            ln_d.aligned              = 1'b1;                           // R17
          end
        end
        default: begin
          ln_d.phase = PH_IDLE;                                         // R21
        end
      endcase
    end
  end

  always_ff @(posedge I_SCK) begin
    ln_q <= ln_d;
  end

  // output changes only after a falling edge; deselect clears it at once, O_SDO_OE within three reference clocks
  always_ff @(negedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      tx_oe_q <= 1'b0;                                                  // R6
      sdo_q   <= 1'b0;
    end else begin
      tx_oe_q <= (ln_q.phase == PH_RDATA) || (ln_q.phase == PH_SFETCH); // R3
      sdo_q   <= ln_q.tx[3'h7 - ln_q.bitcnt];                           // R26
    end
  end

  // --------------------------------------------------------------------
  // reference side: program engine and status
  // --------------------------------------------------------------------
  function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [1:0] p);
    case (p)
      PROT_NONE: prot_hit = 1'b0;
      PROT_QTR:  prot_hit = (a >= PROT_QTR_BASE);
      PROT_HALF: prot_hit = (a >= PROT_HALF_BASE);
      default:   prot_hit = 1'b1;
    endcase
  endfunction : prot_hit

  // frame fields are read only after the synchronised deselect, when the
  // serial clock has stopped and they stand still until the next frame
  always_comb begin
    rf_d    = rf_q;
    wr_go   = 1'b0;
    rf_d.cs_prev = cs_s;
    rf_d.oe      = oe_s & ~cs_s & hold_s;                               // R6
    rise    = cs_s & ~rf_q.cs_prev & ~sck_s;                            // R19
    if (rise) begin
      case (ln_q.kind)
        K_SET: begin
          rf_d.armed = 1'b1;                                            // R8
        end
        K_CLR: begin
          rf_d.armed = 1'b0;                                            // R24
        end
        K_SPROG: begin
          if (ln_q.aligned && (ln_q.phase == PH_SDONE) && rf_q.armed && !rf_q.busy) begin
            rf_d.busy      = 1'b1;                                      // R25
            rf_d.cnt       = CYC_CNT_W'(P_WRITE_CYCLES - 1);
            rf_d.pend_stat = 1'b1;
            rf_d.new_prot  = ln_q.sdata;
          end
        end
        K_WRITE: begin
          if (ln_q.aligned && (ln_q.phase == PH_WDATA) && rf_q.armed && !rf_q.busy) begin
            rf_d.busy = 1'b1;                                           // R13
            rf_d.cnt  = CYC_CNT_W'(P_WRITE_CYCLES - 1);                 // R27
            wr_go     = 1'b1;                                           // R17
          end
        end
        default: begin
          rf_d.busy = rf_q.busy;
        end
      endcase
    end
    if (rf_q.busy) begin
      if (rf_q.cnt == CYC_CNT_W'(ARM_CLEAR_LEAD)) begin
        rf_d.armed = 1'b0;                                              // R14
      end
      if (rf_q.cnt == '0) begin
        rf_d.busy      = 1'b0;                                          // R13
        rf_d.pend_stat = 1'b0;
        if (rf_q.pend_stat) begin
          rf_d.prot  = rf_q.new_prot;                                   // R23
          rf_d.armed = 1'b0;
        end
      end else begin
        rf_d.cnt = rf_q.cnt - 1'b1;                                     // R27
      end
    end
    if (!lock_s) begin
      rf_d.armed = 1'b0;                                                // R22
    end
    if (I_SRST) begin
      rf_d      = REF_INIT;                                             // R18
      rf_d.prot = rf_q.prot;                                            // R18
      wr_go     = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    rf_q <= rf_d;
    if (wr_go) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (ln_q.wmask[i] && !prot_hit({ln_q.addr[9:4], 4'(i)}, rf_q.prot)) begin
          mem[{ln_q.addr[9:4], 4'(i)}] <= ln_q.wbuf[i];                 // R10
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  assign O_SDO           = sdo_q;
  assign O_SDO_OE        = rf_q.oe;
  assign O_CYCLE_ACTIVE  = rf_q.busy;
  assign O_PROGRAM_ARMED = rf_q.armed;
  assign O_PROTECT_SEL   = rf_q.prot;

endmodule : secs_top
`default_nettype wire

//--- tb/secs_asserts.sv
// Purpose: port timing checks of the serial eeprom command slave
// Assumes: every check is judged on the reference clock
// Notes:   serial data contents are judged by the bench
`timescale 1ns/10ps
`default_nettype none
module secs_asserts #(
  parameter int P_WRITE_CYCLES = 64  // program cycle length
) (
  input wire logic       I_REF_CLK,       // system clock
  input wire logic       I_SRST,          // synchronous reset
  input wire logic       I_CS_N,          // chip enable
  input wire logic       I_LOCK_N,        // program lock
  input wire logic       O_SDO_OE,        // output enable
  input wire logic       O_CYCLE_ACTIVE,  // program cycle running
  input wire logic       O_PROGRAM_ARMED, // write latch
  input wire logic [1:0] O_PROTECT_SEL    // protect bits
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SRST);
  // counts how long the program cycle has stood; a repetition would be far too long
  int busy_cnt_q;
  always_ff @(posedge I_REF_CLK) begin
    busy_cnt_q <= O_CYCLE_ACTIVE ? busy_cnt_q + 1 : 0;
  end
  a_reset_idle: assert property (
    $fell(I_SRST) |-> !O_CYCLE_ACTIVE && !O_PROGRAM_ARMED && !O_SDO_OE)
    else $error("outputs not idle after reset");
  a_busy_length: assert property (
    $fell(O_CYCLE_ACTIVE) |-> busy_cnt_q == P_WRITE_CYCLES)
    else $error("program cycle length wrong");
  a_armed_end: assert property ($fell(O_CYCLE_ACTIVE) |-> !O_PROGRAM_ARMED)
    else $error("latch still armed at cycle end");
  a_busy_armed: assert property ($rose(O_CYCLE_ACTIVE) |-> O_PROGRAM_ARMED && I_LOCK_N)
    else $error("program cycle without armed latch");
  a_busy_desel: assert property ($rose(O_CYCLE_ACTIVE) |-> I_CS_N && $past(I_CS_N, 3))
    else $error("program cycle started while selected");
  a_oe_idle: assert property (I_CS_N [*5] |-> !O_SDO_OE)
    else $error("output driven while deselected");
  a_prot_change: assert property (
    $changed(O_PROTECT_SEL) |->
      !O_CYCLE_ACTIVE && ($past(O_CYCLE_ACTIVE) || $past(O_CYCLE_ACTIVE, 2)))
    else $error("protect bits changed outside cycle end");
  a_arm_desel: assert property ($rose(O_PROGRAM_ARMED) |-> I_CS_N && I_LOCK_N)
    else $error("latch armed while selected");
  a_lock_clear: assert property (!I_LOCK_N [*4] |-> !O_PROGRAM_ARMED)
    else $error("lock low did not clear latch");
  c_cycle: cover property ($rose(O_CYCLE_ACTIVE));
  c_read_out: cover property ($rose(O_SDO_OE));
  c_prot_all: cover property (O_PROTECT_SEL == 2'h3);
endmodule : secs_asserts

bind secs_top secs_asserts #(.P_WRITE_CYCLES(P_WRITE_CYCLES)) u_secs_asserts (
  .I_REF_CLK(I_REF_CLK), .I_SRST(I_SRST), .I_CS_N(I_CS_N), .I_LOCK_N(I_LOCK_N),
  .O_SDO_OE(O_SDO_OE), .O_CYCLE_ACTIVE(O_CYCLE_ACTIVE),
  .O_PROGRAM_ARMED(O_PROGRAM_ARMED), .O_PROTECT_SEL(O_PROTECT_SEL));
`default_nettype wire

//--- tb/secs_master.sv
// Purpose: mode 0 serial bus master facing the eeprom command slave
// Assumes: 15 ns serial clock that runs only inside frames
// Notes:   data line shows the inverse of its last bit once released
`timescale 1ns/10ps
`default_nettype none
module secs_master (
  output logic      o_sck,    // serial clock
  output logic      o_cs_n,   // chip enable
  output logic      o_sdi,    // data to device
  output logic      o_hold_n, // pause
  input  wire logic i_sdo     // data from device
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
    o_hold_n = 1'b1;
  end
  task automatic sel();
    #4.3;
    o_cs_n = 1'b0;
    #7.5;
  endtask : sel
  task automatic clk_bit(input logic b, output logic r);
    o_sdi = b;
    #7.5;
    o_sck = 1'b1;
    r = i_sdo;
    #7.5;
    o_sck = 1'b0;
  endtask : clk_bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) clk_bit(tx[i], rx[i]);
  endtask : xfer
  // a stray partial byte, sent only where a scenario asks for a cancel
  task automatic part(input logic [2:0] v);
    logic r;
    for (int i = 2; i >= 0; i--) clk_bit(v[i], r);
  endtask : part
  task automatic hpulse();
    logic r;
    o_hold_n = 1'b0;
    clk_bit(~o_sdi, r);
    o_hold_n = 1'b1;
  endtask : hpulse
  task automatic desel();
    #3;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #300;
  endtask : desel
endmodule : secs_master
`default_nettype wire

//--- tb/test_spi_eeprom_command_slave.sv
// Purpose: self-checking bench of the serial eeprom command slave
// Assumes: mode 0 link at 15 ns, program cycle shortened to WC clocks
// Notes:   array, latch and protect bits are mirrored in integer models
`timescale 1ns/10ps
`default_nettype none
module test_spi_eeprom_command_slave;
  import secs_pkg::*;
  localparam int WC = 200;  // short cycle keeps the run brief
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        lock_n = 1'b1;
  logic [7:0]  rx;
  logic [31:0] rng = 32'h871a69b2;
  logic [9:0]  base [4] = '{10'h3ff, PROT_QTR_BASE, PROT_HALF_BASE, 10'h000};
  wire logic   sck, cs_n, sdi, hold_n, sdo, sdo_oe, busy, armed_o;
  wire logic [1:0] prot_o;
  int          errors = 0;
  int          comparisons = 0;
  int          prot = 0;
  int          armed = 0;
  int          mem [MEM_DEPTH];

  always #10 ref_clk = ~ref_clk;

  secs_top #(.P_WRITE_CYCLES(WC)) uut (
    .I_REF_CLK(ref_clk), .I_SRST(srst), .I_SCK(sck), .I_CS_N(cs_n),
    .I_SDI(sdi), .I_HOLD_N(hold_n), .I_LOCK_N(lock_n), .O_SDO(sdo),
    .O_SDO_OE(sdo_oe), .O_CYCLE_ACTIVE(busy), .O_PROGRAM_ARMED(armed_o),
    .O_PROTECT_SEL(prot_o));
  secs_master mst (.o_sck(sck), .o_cs_n(cs_n), .o_sdi(sdi), .o_hold_n(hold_n), .i_sdo(sdo));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic cmd(input logic [7:0] op);
    mst.sel();
    mst.xfer(op, rx);
    mst.desel();
  endtask : cmd
  // the bound only guards a hang; the following compare catches an overrun
  task automatic wait_idle();
    for (int k = 0; k < 2 * WC && busy !== 1'b0; k++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(busy, 0);
  endtask : wait_idle
  task automatic st(input int b, input logic hold);
    mst.sel();
    if (hold) mst.hpulse();
    mst.xfer(8'h1d, rx);
    mst.xfer(8'(xs()), rx);
    chk(rx, 32'hf0 | prot << 2 | armed << 1 | b);
    mst.xfer(8'(xs()), rx);
    chk(sdo_oe, 0);
    mst.desel();
  endtask : st
  task automatic rd(input logic [9:0] a, input int n);
    mst.sel();
    mst.xfer({3'h0, a[9:8], OP_ARRAY_READ}, rx);
    mst.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      mst.xfer(8'(xs()), rx);
      chk(rx, mem[a]);
      a = (a == ADDR_WRAP) ? 10'h000 : a + 10'h001;
    end
    chk(sdo_oe, 1);
    mst.desel();
  endtask : rd
  task automatic wr(input logic [9:0] a, input int n, input logic cut);
    logic [7:0] d;
    int hit;
    hit = prot == 3 || (prot == 2 && a >= PROT_HALF_BASE) || (prot == 1 && a >= PROT_QTR_BASE);
    mst.sel();
    mst.xfer({3'h0, a[9:8], OP_ARRAY_WRITE}, rx);
    mst.xfer(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      d = 8'(xs());
      mst.xfer(d, rx);
      if (armed && !cut && !hit) mem[{a[9:4], 4'(a[3:0] + i)}] = d;
    end
    if (cut) mst.part(3'h5);
    mst.desel();
    if (armed && !cut && !hit) begin
      chk(busy, 1);
      st(1, 0);
      mst.sel();
      mst.xfer({3'h0, a[9:8], OP_ARRAY_READ}, rx);
      mst.xfer(a[7:0], rx);
      mst.xfer(8'h00, rx);
      chk(sdo_oe, 0);
      mst.desel();
      chk(busy, 1);
      armed = 0;
    end else if (!hit) chk(busy, 0);
    wait_idle();
    if (hit) cmd(8'h04);
    if (hit) armed = 0;
    chk(armed_o, armed);
    rd(a, 1);
  endtask : wr
  task automatic stp(input int p);
    cmd(8'h06);
    armed = 1;
    mst.sel();
    mst.xfer({3'h0, 2'h3, OP_STATUS_PROGRAM}, rx);
    mst.xfer({4'h0, 2'(p), 2'h0}, rx);
    mst.desel();
    chk(busy, 1);
    wait_idle();
    prot = p;
    armed = 0;
    chk(prot_o, prot);
    chk(armed_o, 0);
  endtask : stp

  initial begin : main
    foreach (mem[i]) mem[i] = 255;
    repeat (10) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({busy, armed_o, sdo_oe}, 0);
    chk(prot_o, PROT_INIT);
    st(0, 1);
    rd(10'(xs()), 3);
    cmd(8'h1e);
    armed = 1;
    chk(armed_o, 1);
    cmd(8'h1c);
    armed = 0;
    chk(armed_o, 0);
    cmd(8'h26);
    chk(armed_o, 0);
    mst.sel();
    mst.xfer(8'h07, rx);
    mst.xfer(8'h00, rx);
    chk(sdo_oe, 0);
    mst.desel();
    wr(10'(xs()), 1, 0);
    cmd(8'h06);
    armed = 1;
    wr(10'h1f3, 17, 0);
    rd(10'h1f0, 18);
    cmd(8'h06);
    armed = 1;
    wr(10'(xs()), 2, 1);
    @(posedge ref_clk);
    #1 lock_n = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 lock_n = 1'b1;
    armed = 0;
    chk(armed_o, 0);
    wr(10'(xs()), 1, 0);
    for (int p = 1; p < 5; p++) begin
      stp(p % 4);
      cmd(8'h06);
      armed = 1;
      wr(base[p % 4] - 10'h001, 1, 0);
      cmd(8'h06);
      armed = 1;
      wr(base[p % 4], 1, 0);
    end
    wrap_up();
  end
  initial begin : watchdog
    #1500000;
    errors++;
    wrap_up();
  end
endmodule : test_spi_eeprom_command_slave
`default_nettype wire
